// ===== include/ohcis_pkg.sv
// constants shared by the command and event-status register bank
package ohcis_pkg;

  // register offsets relative to the operational base address
  localparam logic [7:0] CMD_OFFSET = 8'h08;
  localparam logic [7:0] EVT_OFFSET = 8'h0c;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // command register field positions
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_CTRL_FILLED_BIT = 1;
  localparam int CMD_BULK_FILLED_BIT = 2;
  localparam int CMD_OWN_REQ_BIT = 3;
  localparam int CMD_OVR_CNT_LSB = 16;
  localparam int OVR_CNT_W = 2;

  // event-status and enable field positions
  localparam int EVT_OVERRUN = 0;
  localparam int EVT_DONE_HEAD = 1;
  localparam int EVT_SOF = 2;
  localparam int EVT_RESUME = 3;
  localparam int EVT_UNRECOV = 4;
  localparam int EVT_FRAME_OVF = 5;
  localparam int EVT_ROOT_HUB = 6;
  localparam int EVT_LOW_COUNT = 7;
  localparam int EVT_OWN_CHANGE = 30;
  localparam int ENA_MASTER = 31;

  // frame number bit whose toggle marks an overflow
  localparam int FRAME_MSB = 15;

  // reset values
  localparam logic [DATA_W-1:0] CMD_RESET_VAL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EVT_RESET_VAL = 32'h0000_0000;
  localparam logic [OVR_CNT_W-1:0] OVR_CNT_RESET = 2'h0;

  // software reset must finish within this time
  localparam int SOFT_RESET_MAX_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_MAX_US * CLK_MHZ;

  // software reset sequencer
  typedef enum logic {SRST_IDLE, SRST_BUSY} ohcis_srst_t;

endpackage

// ===== src/ohcis_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module ohcis_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // async level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== src/ohcis_flag.sv
// one sticky event flag, set by hardware, cleared by a software write of one
`timescale 1ns/100ps
`default_nettype none
module ohcis_flag (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // hardware event and software clear strobe
  input wire logic set,
  input wire logic sw_clear,
  // sticky flag
  output logic flag_q
);

  logic flag_d;

  // set wins over a clear in the same cycle so no event is lost
  assign flag_d = set ? 1'b1 : (sw_clear ? 1'b0 : flag_q); // see R12

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n) set |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost"); // see R11

  property p_w1c;
    @(posedge clk) disable iff (!rst_n) (sw_clear && !set) |=> !flag_q;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // see R12

  property p_no_self_clear;
    @(posedge clk) disable iff (!rst_n) (flag_q && !sw_clear) |=> flag_q;
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("flag dropped"); // see R12

endmodule
`default_nettype wire

// ===== src/ohcis_command_irq_status.sv
// command bits, event-status flags and interrupt request of the host controller
//
// Contract
// R01: a software ownership change request sets the ownership change flag
// R02: the request bit clears after changeover and stays clear until requested again
// R03: software sets bulk list filled whenever it adds bulk work
// R04: at bulk head, skip when bit is 0, else start and clear the bit
// R05: a found bulk descriptor sets the bit again, otherwise bulk stops at list end
// R06: control list filled: software sets it, head skips on 0, starts and clears on 1
// R07: a found control descriptor sets the bit again, otherwise control stops at end
// R08: reset command enters suspend, resets operational state, blocks bus accesses
// R09: the reset command bit self-clears when reset completes, within 10 us
// R10: software reset never resets the root hub nor signals reset on ports
// R11: events set their flag; interrupt only when its enable and master enable set
// R12: writing one clears a flag, zero leaves it; only hardware sets, never clears
// R13: an unmasked ownership change flag raises system management interrupt; zero without pin
// R14: root hub or port status change sets root hub change flag
// R15: frame number bit 15 toggle or shared frame copy update sets overflow flag
// R16: system error sets unrecoverable flag and halts processing until corrected
// R17: resume flag sets on resume signaling onset, not on commanded resume
// R18: start-of-frame flag sets together with the SOF token
// R19: done-head flag sets after write-back; further write-backs wait for its clear
// R20: software clears done-head flag only after saving the queue head
// R21: a scheduling overrun sets the overrun flag and bumps the two-bit count
// R22: software writes reserved event-status bits as zero
// R23: overrun count resets to zero, wraps, counts even when flag already set
// R24: command register is write-one-to-set and reads back normally
// R25: registered interrupt request is OR of enabled flags gated by master enable
`timescale 1ns/100ps
`default_nettype none
module ohcis_command_irq_status #(
  parameter bit SMI_PRESENT = 1'b1,
  parameter int SOFT_RESET_CYCLES = ohcis_pkg::SOFT_RESET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ohcis_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ohcis_pkg::DATA_W-1:0] reg_wdata,
  output logic [ohcis_pkg::DATA_W-1:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // interrupt enable register contents
  input wire logic [ohcis_pkg::DATA_W-1:0] event_enable,
  // list processing handshakes from the schedule engine
  input wire logic bulk_head_reached,
  input wire logic bulk_td_found,
  input wire logic bulk_list_done,
  input wire logic control_head_reached,
  input wire logic control_td_found,
  input wire logic control_list_done,
  output logic bulk_start_q,
  output logic bulk_skip_q,
  output logic bulk_stop_q,
  output logic control_start_q,
  output logic control_skip_q,
  output logic control_stop_q,
  // ownership and software reset
  input wire logic changeover_done,
  input wire logic soft_reset_done,
  output logic soft_reset_q,
  output logic suspend_enter_q,
  output logic bus_hold_q,
  // hardware events
  input wire logic root_hub_changed,
  input wire logic [ohcis_pkg::FRAME_MSB:0] frame_number,
  input wire logic shared_frame_updated,
  input wire logic system_error,
  input wire logic resume_signal,
  input wire logic resume_state_cmd,
  input wire logic sof_issued,
  input wire logic done_head_written,
  input wire logic sched_overrun,
  // status and interrupt outputs
  output logic halt_q,
  output logic done_head_hold,
  output logic irq_q,
  output logic smi_q
);

  localparam int CW = $clog2(SOFT_RESET_CYCLES + 1);
  localparam logic [CW-1:0] SRST_LAST = CW'(SOFT_RESET_CYCLES - 1);
  localparam int NLOW = ohcis_pkg::EVT_LOW_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_q;
  logic rst_n;

  // async assert, two-flop release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire cmd_hit = (reg_addr == ohcis_pkg::CMD_OFFSET);
  wire evt_hit = (reg_addr == ohcis_pkg::EVT_OFFSET);
  wire cmd_wr = reg_wr & cmd_hit;
  wire evt_wr = reg_wr & evt_hit;

  // write-one-to-set strobes, zeros leave bits alone
  wire sw_set_reset = cmd_wr & reg_wdata[ohcis_pkg::CMD_RESET_BIT]; // see R24
  wire sw_set_clf = cmd_wr & reg_wdata[ohcis_pkg::CMD_CTRL_FILLED_BIT]; // see R24
  wire sw_set_blf = cmd_wr & reg_wdata[ohcis_pkg::CMD_BULK_FILLED_BIT]; // see R24
  wire sw_set_ocr = cmd_wr & reg_wdata[ohcis_pkg::CMD_OWN_REQ_BIT]; // see R24

  // write-one-to-clear strobes; reserved bits are not stored at all
  wire [NLOW-1:0] sw_clr_low = {NLOW{evt_wr}} & reg_wdata[NLOW-1:0]; // see R12
  wire sw_clr_oc = evt_wr & reg_wdata[ohcis_pkg::EVT_OWN_CHANGE]; // see R12

  ////////////////////////////////////////////////////////////////////////////
  // software reset sequencer

  ohcis_pkg::ohcis_srst_t srst_state_q;
  ohcis_pkg::ohcis_srst_t srst_state_d;
  logic [CW-1:0] srst_cnt_q;
  logic [CW-1:0] srst_cnt_d;

  wire srst_busy = (srst_state_q == ohcis_pkg::SRST_BUSY);
  wire srst_entry = ~srst_busy & sw_set_reset; // see R08
  // the core may finish early; the counter caps the time
  wire srst_done = srst_busy & (soft_reset_done | (srst_cnt_q == SRST_LAST)); // see R09

  // only controller-side state is cleared; the root hub and ports are never touched, see R10
  always_comb
  begin
    srst_state_d = srst_state_q;
    srst_cnt_d = srst_cnt_q;
    unique case (srst_state_q)
      ohcis_pkg::SRST_IDLE:
      begin
        srst_cnt_d = '0;
        if (sw_set_reset)
          srst_state_d = ohcis_pkg::SRST_BUSY; // see R08
      end
      ohcis_pkg::SRST_BUSY:
      begin
        srst_cnt_d = CW'(srst_cnt_q + 1'b1);
        if (srst_done)
          srst_state_d = ohcis_pkg::SRST_IDLE; // see R09
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srst_state_q <= ohcis_pkg::SRST_IDLE;
      srst_cnt_q <= '0;
    end
    else
    begin
      srst_state_q <= srst_state_d;
      srst_cnt_q <= srst_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command bits

  logic ocr_q;
  logic blf_q;
  logic clf_q;
  logic [ohcis_pkg::OVR_CNT_W-1:0] soc_q;

  // hardware re-arm from a found descriptor counts as a set
  wire blf_set = sw_set_blf | bulk_td_found; // see R05
  wire clf_set = sw_set_clf | control_td_found; // see R07
  wire blf_take = bulk_head_reached & blf_q; // see R04
  wire clf_take = control_head_reached & clf_q; // see R06

  // set wins over any clear in the same cycle
  wire ocr_d = sw_set_ocr ? 1'b1 : ((changeover_done | srst_entry) ? 1'b0 : ocr_q); // see R02
  wire blf_d = blf_set ? 1'b1 : ((blf_take | srst_entry) ? 1'b0 : blf_q); // see R04
  wire clf_d = clf_set ? 1'b1 : ((clf_take | srst_entry) ? 1'b0 : clf_q); // see R06

  // counter wraps at its width; it counts even if the overrun flag is set
  wire [ohcis_pkg::OVR_CNT_W-1:0] soc_d = sched_overrun ?
    ohcis_pkg::OVR_CNT_W'(soc_q + 1'b1) : // see R23
    (srst_entry ? ohcis_pkg::OVR_CNT_RESET : soc_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocr_q <= ohcis_pkg::CMD_RESET_VAL[ohcis_pkg::CMD_OWN_REQ_BIT];
      blf_q <= ohcis_pkg::CMD_RESET_VAL[ohcis_pkg::CMD_BULK_FILLED_BIT];
      clf_q <= ohcis_pkg::CMD_RESET_VAL[ohcis_pkg::CMD_CTRL_FILLED_BIT];
      soc_q <= ohcis_pkg::OVR_CNT_RESET;
    end
    else
    begin
      ocr_q <= ocr_d;
      blf_q <= blf_d;
      clf_q <= clf_d;
      soc_q <= soc_d; // see R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // list processing decisions

  // stop only when nobody re-armed the bit during the walk
  wire bulk_stop = bulk_list_done & ~blf_q & ~blf_set; // see R05
  wire control_stop = control_list_done & ~clf_q & ~clf_set; // see R07

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bulk_start_q <= 1'b0;
      bulk_skip_q <= 1'b0;
      bulk_stop_q <= 1'b0;
      control_start_q <= 1'b0;
      control_skip_q <= 1'b0;
      control_stop_q <= 1'b0;
    end
    else
    begin
      bulk_start_q <= blf_take; // see R04
      bulk_skip_q <= bulk_head_reached & ~blf_q; // see R04
      bulk_stop_q <= bulk_stop;
      control_start_q <= clf_take; // see R06
      control_skip_q <= control_head_reached & ~clf_q; // see R06
      control_stop_q <= control_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event sources

  logic resume_sync;
  logic resume_prev_q;
  logic frame_msb_prev_q;

  // resume line comes from the port, so it is synchronised first
  ohcis_sync #(.W(1)) u_resume_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(resume_signal),
    .sync_out(resume_sync)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resume_prev_q <= 1'b0;
      frame_msb_prev_q <= 1'b0;
    end
    else
    begin
      resume_prev_q <= resume_sync;
      frame_msb_prev_q <= frame_number[ohcis_pkg::FRAME_MSB];
    end
  end

  wire resume_onset = resume_sync & ~resume_prev_q & ~resume_state_cmd; // see R17
  wire frame_toggle = frame_number[ohcis_pkg::FRAME_MSB] ^ frame_msb_prev_q; // see R15

  logic [NLOW-1:0] evt_set;
  logic [NLOW-1:0] evt_flag;
  logic oc_flag;

  // one set strobe per flag
  assign evt_set[ohcis_pkg::EVT_OVERRUN] = sched_overrun; // see R21
  assign evt_set[ohcis_pkg::EVT_DONE_HEAD] = done_head_written; // see R19
  assign evt_set[ohcis_pkg::EVT_SOF] = sof_issued; // see R18
  assign evt_set[ohcis_pkg::EVT_RESUME] = resume_onset; // see R17
  assign evt_set[ohcis_pkg::EVT_UNRECOV] = system_error; // see R16
  assign evt_set[ohcis_pkg::EVT_FRAME_OVF] = frame_toggle | shared_frame_updated; // see R15
  assign evt_set[ohcis_pkg::EVT_ROOT_HUB] = root_hub_changed; // see R14

  // without the management pin the flag can never set and reads zero
  wire oc_set = SMI_PRESENT & sw_set_ocr; // see R13

  ////////////////////////////////////////////////////////////////////////////
  // event-status flags

  // flags survive software reset: hardware never clears them itself
  for (genvar i = 0; i < NLOW; i++)
  begin : g_flag
    ohcis_flag u_flag (
      .clk(clk),
      .rst_n(rst_n),
      .set(evt_set[i]), // see R11
      .sw_clear(sw_clr_low[i]),
      .flag_q(evt_flag[i])
    );
  end

  ohcis_flag u_oc_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(oc_set), // see R01
    .sw_clear(sw_clr_oc),
    .flag_q(oc_flag)
  );

  // done-head write-backs wait while the flag is pending
  assign done_head_hold = evt_flag[ohcis_pkg::EVT_DONE_HEAD]; // see R19

  ////////////////////////////////////////////////////////////////////////////
  // interrupts, halt and bus hold

  wire master_en = event_enable[ohcis_pkg::ENA_MASTER];
  wire irq_d = master_en & (|(evt_flag & event_enable[NLOW-1:0])); // see R25
  wire smi_d = master_en & oc_flag & event_enable[ohcis_pkg::EVT_OWN_CHANGE]; // see R13
  // a system error halts until software resets the controller
  wire halt_d = system_error | (halt_q & ~srst_done); // see R16

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
      smi_q <= 1'b0;
      halt_q <= 1'b0;
      soft_reset_q <= 1'b0;
      suspend_enter_q <= 1'b0;
      bus_hold_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d; // see R11
      smi_q <= smi_d;
      halt_q <= halt_d;
      soft_reset_q <= (srst_state_d == ohcis_pkg::SRST_BUSY); // see R08
      suspend_enter_q <= srst_entry; // see R08
      bus_hold_q <= halt_d | (srst_state_d == ohcis_pkg::SRST_BUSY); // see R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [ohcis_pkg::DATA_W-1:0] cmd_word;
  logic [ohcis_pkg::DATA_W-1:0] evt_word;

  // reserved positions read as zero
  always_comb
  begin
    cmd_word = '0;
    cmd_word[ohcis_pkg::CMD_RESET_BIT] = srst_busy; // see R09
    cmd_word[ohcis_pkg::CMD_CTRL_FILLED_BIT] = clf_q;
    cmd_word[ohcis_pkg::CMD_BULK_FILLED_BIT] = blf_q;
    cmd_word[ohcis_pkg::CMD_OWN_REQ_BIT] = ocr_q;
    cmd_word[ohcis_pkg::CMD_OVR_CNT_LSB +: ohcis_pkg::OVR_CNT_W] = soc_q;
    evt_word = '0;
    evt_word[NLOW-1:0] = evt_flag;
    evt_word[ohcis_pkg::EVT_OWN_CHANGE] = oc_flag;
  end

  wire [ohcis_pkg::DATA_W-1:0] rd_sel = cmd_hit ? cmd_word : (evt_hit ? evt_word : '0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= '0;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q <= reg_rd ? rd_sel : '0;
      reg_rvalid_q <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_srst_start;
    !srst_busy ##0 sw_set_reset;
  endsequence

  sequence s_srst_held;
    soft_reset_q && bus_hold_q && suspend_enter_q;
  endsequence

  property p_own_change;
    @(posedge clk) disable iff (!rst_n) (sw_set_ocr && SMI_PRESENT) |=> oc_flag && ocr_q;
  endproperty
  a_own_change: assert property (p_own_change) else $error("no ownership flag"); // see R01

  property p_ocr_clear;
    @(posedge clk) disable iff (!rst_n) (changeover_done && !sw_set_ocr) |=> !ocr_q;
  endproperty
  a_ocr_clear: assert property (p_ocr_clear) else $error("request not cleared"); // see R02

  property p_bulk_take;
    @(posedge clk) disable iff (!rst_n)
      (bulk_head_reached && blf_q && !blf_set) |=> (bulk_start_q && !blf_q && !bulk_skip_q);
  endproperty
  a_bulk_take: assert property (p_bulk_take) else $error("bulk start wrong"); // see R04

  property p_bulk_rearm;
    @(posedge clk) disable iff (!rst_n) bulk_td_found |=> blf_q && !bulk_stop_q;
  endproperty
  a_bulk_rearm: assert property (p_bulk_rearm) else $error("bulk not rearmed"); // see R05

  property p_ctrl_skip;
    @(posedge clk) disable iff (!rst_n)
      (control_head_reached && !clf_q) |=> (control_skip_q && !control_start_q);
  endproperty
  a_ctrl_skip: assert property (p_ctrl_skip) else $error("control skip wrong"); // see R06

  property p_ctrl_rearm;
    @(posedge clk) disable iff (!rst_n) control_td_found |=> clf_q;
  endproperty
  a_ctrl_rearm: assert property (p_ctrl_rearm) else $error("control not rearmed"); // see R07

  property p_srst_enter;
    @(posedge clk) disable iff (!rst_n) s_srst_start |=> s_srst_held ##1 !suspend_enter_q;
  endproperty
  a_srst_enter: assert property (p_srst_enter) else $error("reset entry wrong"); // see R08

  property p_srst_bound;
    @(posedge clk) disable iff (!rst_n) s_srst_start |-> ##[1:1000] srst_done;
  endproperty
  a_srst_bound: assert property (p_srst_bound) else $error("reset too long"); // see R09

  property p_overrun_count;
    @(posedge clk) disable iff (!rst_n)
      sched_overrun |=> (soc_q == ohcis_pkg::OVR_CNT_W'($past(soc_q) + 1'b1))
        && evt_flag[ohcis_pkg::EVT_OVERRUN];
  endproperty
  a_overrun_count: assert property (p_overrun_count) else $error("overrun count wrong"); // see R23

  property p_irq_master;
    @(posedge clk) disable iff (!rst_n) !master_en |=> !irq_q && !smi_q;
  endproperty
  a_irq_master: assert property (p_irq_master) else $error("irq without master"); // see R25

  property p_halt;
    @(posedge clk) disable iff (!rst_n) system_error |=> halt_q && bus_hold_q;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt on error"); // see R16

  property p_frame_ovf;
    @(posedge clk) disable iff (!rst_n) frame_toggle |=> evt_flag[ohcis_pkg::EVT_FRAME_OVF];
  endproperty
  a_frame_ovf: assert property (p_frame_ovf) else $error("overflow missed"); // see R15

endmodule
`default_nettype wire

// ===== tb/ohcis_host_model.sv
// driver-software model issuing register strobes to the bank
`timescale 1ns/100ps
`default_nettype none
module ohcis_host_model (
  // clock
  input wire logic clk,
  // register strobes toward the bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [ohcis_pkg::ADDR_W-1:0] reg_addr,
  output logic [ohcis_pkg::DATA_W-1:0] reg_wdata
);
  //////////////////////////////////////////////////////////////////////
  // idle lines at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
  end
  // one strobe cycle; stale address and data are inverted so they never look valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = (a == ohcis_pkg::EVT_OFFSET) ? (d & 32'h4000_007f) : d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ===== tb/ohcis_command_irq_status_tb.sv
// self-checking bench for the command and event-status bank
`timescale 1ns/100ps
`default_nettype none
module ohcis_command_irq_status_tb;
  localparam int SRC = 20;
  localparam logic [7:0] C = ohcis_pkg::CMD_OFFSET;
  localparam logic [7:0] E = ohcis_pkg::EVT_OFFSET;
  logic clk, reset_n, reg_wr, reg_rd, reg_rvalid_q, soft_reset_q, suspend_enter_q, bus_hold_q;
  logic resume_signal, resume_state_cmd, halt_q, done_head_hold, irq_q, smi_q;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, event_enable;
  logic [31:0] seed = 32'hee45;
  logic [15:0] frame_number;
  logic [14:0] pv;
  logic [1:0] ls, lk, lp;
  logic [6:0] flg;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  //////////////////////////////////////////////////////////////////////
  // clock, partner and design
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ohcis_host_model u_ohcis_host_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  ohcis_command_irq_status #(.SOFT_RESET_CYCLES(SRC)) u_ohcis_command_irq_status (
    .clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q,
    .event_enable, .bulk_head_reached(pv[0]), .control_head_reached(pv[1]),
    .bulk_td_found(pv[2]), .control_td_found(pv[3]), .bulk_list_done(pv[4]),
    .control_list_done(pv[5]), .bulk_start_q(ls[0]), .control_start_q(ls[1]),
    .bulk_skip_q(lk[0]), .control_skip_q(lk[1]), .bulk_stop_q(lp[0]), .control_stop_q(lp[1]),
    .changeover_done(pv[13]), .soft_reset_done(pv[14]), .soft_reset_q, .suspend_enter_q,
    .bus_hold_q, .root_hub_changed(pv[12]), .frame_number, .shared_frame_updated(pv[11]),
    .system_error(pv[10]), .resume_signal, .resume_state_cmd, .sof_issued(pv[8]),
    .done_head_written(pv[7]), .sched_overrun(pv[6]), .halt_q, .done_head_hold, .irq_q, .smi_q);
  //////////////////////////////////////////////////////////////////////
  // helpers: random source, waits, pulses, register access, compare, verdict
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pls(input int b);
    pv[b] = 1'b1;
    tick(1);
    pv = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ohcis_host_model.access(1'b1, a, d);
  endtask
  // the expectation is noted before the strobe; the watcher pops it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_ohcis_host_model.access(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    // a read that never answered leaves its note behind
    if (exp_q.size() != 0)
      mismatches++;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read answers are compared mid-cycle, where they have settled
  always @(negedge clk)
  begin
    if (reg_rvalid_q === 1'b1)
      chk("read", exp_q.pop_front(), reg_rdata_q);
  end
  // hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    pv = '0;
    event_enable = 32'h0;
    resume_signal = 1'b0;
    resume_state_cmd = 1'b0;
    frame_number = 16'(xs() & 32'h7fff);
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick(3);
    rd(C, 32'h0);
    rd(E, 32'h0);
    rd(8'h04, 32'h0);
    // bulk list then control list: start, skip, re-arm, stop
    for (int i = 0; i < 2; i++)
    begin
      wr(C, 32'h4 >> i);
      rd(C, 32'h4 >> i);
      pls(i);
      chk("start", 1, ls[i]);
      rd(C, 32'h0);
      pls(i);
      chk("skip", 1, lk[i]);
      pls(2 + i);
      rd(C, 32'h4 >> i);
      pls(i);
      tick(1);
      pls(4 + i);
      chk("stop", 1, lp[i]);
    end
    // ownership change request
    event_enable = 32'hc000_0000;
    wr(C, 32'h8);
    tick(1);
    chk("smi", 1, smi_q);
    rd(E, 32'h4000_0000);
    pls(13);
    rd(C, 32'h0);
    wr(E, 32'h4000_0000);
    rd(E, 32'h0);
    // each hardware event except resume under a random enable mask
    flg = '0;
    for (int i = 0; i < 7; i++)
    begin
      if (i != 3)
      begin
        event_enable = xs() & 32'h8000_007f;
        pls(6 + i);
        tick(1);
        flg[i] = 1'b1;
        chk("irq", event_enable[31] & |(flg & event_enable[6:0]), irq_q);
      end
    end
    rd(E, {25'h0, flg});
    chk("hold", 1, done_head_hold);
    chk("halt", 1, halt_q);
    chk("bushold", 1, bus_hold_q);
    wr(E, 32'h0);
    rd(E, {25'h0, flg});
    wr(E, 32'h7e);
    rd(E, 32'h1);
    // overrun held high for five edges counts five overruns
    pv[6] = 1'b1;
    tick(5);
    pv = '0;
    rd(C, 32'h0002_0000);
    frame_number[15] = 1'b1;
    tick(2);
    rd(E, 32'h21);
    wr(E, 32'h21);
    // resume onset, first while commanded, then from a device
    resume_state_cmd = 1'b1;
    resume_signal = 1'b1;
    tick(6);
    rd(E, 32'h0);
    resume_signal = 1'b0;
    resume_state_cmd = 1'b0;
    tick(4);
    resume_signal = 1'b1;
    tick(6);
    rd(E, 32'h8);
    // software reset by timeout, then by early completion
    wr(C, 32'h1);
    chk("suspend", 1, suspend_enter_q);
    chk("srst", 1, soft_reset_q);
    rd(C, 32'h1);
    for (int n = 0; n < 2 * SRC && soft_reset_q !== 1'b0; n++)
      tick(1);
    chk("srst", 0, soft_reset_q);
    chk("halt", 0, halt_q);
    rd(C, 32'h0);
    rd(E, 32'h8);
    wr(C, 32'h1);
    pls(14);
    tick(2);
    chk("srst", 0, soft_reset_q);
    test_done();
  end
endmodule
`default_nettype wire
